// File: verilog/ucbs_params.svh
`ifndef UCBS_PARAMS_SVH
`define UCBS_PARAMS_SVH

// register byte addresses
`define UCBS_ADDR_MODE      16'hff70
`define UCBS_ADDR_DATA      16'hff71
`define UCBS_ADDR_STATUS    16'hff72
`define UCBS_ADDR_BAUD      16'hff76

// reset value of every register
`define UCBS_RESET_BYTE     8'h00

// writable bits of the mode and baud registers
`define UCBS_MODE_WMASK     8'hfe
`define UCBS_BAUD_WMASK     8'h7f

// status register field positions
`define UCBS_STAT_PE        2
`define UCBS_STAT_FE        1
`define UCBS_STAT_OVE       0

// baud generator field positions
`define UCBS_BAUD_PS_HI     6
`define UCBS_BAUD_PS_LO     4
`define UCBS_BAUD_DIV_HI    3
`define UCBS_BAUD_DIV_LO    0

// prescaler code for the external clock pin
`define UCBS_SRC_EXT        3'h0
// divider terminal count is k plus this
`define UCBS_DIV_TERM_OFS   5'h0f
// all-ones prescaler mask for m = 6
`define UCBS_PRESC_ONES     6'h3f

// frame bit counts
`define UCBS_FRAME_BASE     4'h2
`define UCBS_LEN7           4'h7
`define UCBS_LEN8           4'h8

// transmit fifo shape
`define UCBS_FIFO_WIDTH     8
`define UCBS_FIFO_DEPTH     16

`endif

// File: verilog/ucbs_pkg.sv
`default_nettype none

package ucbs_pkg;

    typedef enum logic [1:0] {
        UCBS_PAR_NONE = 2'b00,
        UCBS_PAR_ZERO = 2'b01,
        UCBS_PAR_ODD  = 2'b10,
        UCBS_PAR_EVEN = 2'b11
    } ucbs_parity_t;

    // mode register layout, msb first
    typedef struct packed {
        logic         txe;
        logic         rxe;
        ucbs_parity_t par;
        logic         cl;
        logic         sl;
        logic         isrm;
        logic         rsvd;
    } ucbs_mode_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        bit_op;
        logic [2:0]  bit_sel;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } ucbs_cpu_req_t;

    typedef enum logic {
        UCBS_TX_IDLE  = 1'b0,
        UCBS_TX_SHIFT = 1'b1
    } ucbs_tx_state_t;

    typedef enum logic [1:0] {
        UCBS_RX_IDLE  = 2'b00,
        UCBS_RX_START = 2'b01,
        UCBS_RX_BITS  = 2'b10,
        UCBS_RX_DONE  = 2'b11
    } ucbs_rx_state_t;

endpackage

`default_nettype wire

// File: verilog/ucbs_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module ucbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk_in,
    input  wire logic             reset_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;

    wire push = in_valid_in && in_ready_out;
    wire pop  = out_valid_out && out_ready_in;

    assign in_ready_out  = (count_q != (AW+1)'(DEPTH));
    assign out_valid_out = (count_q != '0);
    assign out_data_out  = mem_q[rd_ptr_q];

    always_ff @(posedge sys_clk_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// File: verilog/ucbs_uart.sv
`timescale 1ns/1ps
`default_nettype none
`include "ucbs_params.svh"

module ucbs_uart (
    input  wire logic                   sys_clk_in,
    input  wire logic                   reset_in,
    input  wire ucbs_pkg::ucbs_cpu_req_t cpu_req_in,
    output logic [7:0]                  cpu_rdata_out,
    output logic                        cpu_rvalid_out,
    output logic                        cpu_tx_ready_out,
    input  wire logic                   serial_in_pin_in,
    output logic                        serial_out_pin_out,
    output logic                        serial_out_pin_oe_out,
    input  wire logic                   external_baud_clock_pin_in,
    output logic                        transmit_done_interrupt_out,
    output logic                        receive_done_interrupt_out
);

    ////////////////////////////////////////////////////////////////////////
    // registers and cpu access

    logic [7:0] mode_q;
    logic [7:0] mode_d;
    logic [7:0] baud_q;
    logic [7:0] baud_d;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] rx_buf_q;
    logic       unread_q;
    logic [7:0] rdata_q;
    logic       rvalid_q;

    ucbs_pkg::ucbs_mode_t mode_w;
    assign mode_w = ucbs_pkg::ucbs_mode_t'(mode_q);

    wire hit_mode   = (cpu_req_in.addr == `UCBS_ADDR_MODE);
    wire hit_data   = (cpu_req_in.addr == `UCBS_ADDR_DATA);
    wire hit_status = (cpu_req_in.addr == `UCBS_ADDR_STATUS);
    wire hit_baud   = (cpu_req_in.addr == `UCBS_ADDR_BAUD);

    wire wr_mode  = cpu_req_in.wr && hit_mode;
    // baud and data take whole-byte writes only
    wire wr_baud  = cpu_req_in.wr && hit_baud && !cpu_req_in.bit_op;
    wire wr_data  = cpu_req_in.wr && hit_data && !cpu_req_in.bit_op;
    wire rd_data  = cpu_req_in.rd && hit_data;

    // single-bit write merges into the current byte
    wire [7:0] bit_mask  = 8'h01 << cpu_req_in.bit_sel;
    wire [7:0] mode_bitw = cpu_req_in.wdata[0] ? (mode_q | bit_mask)
                                               : (mode_q & ~bit_mask);
    wire [7:0] mode_new  = cpu_req_in.bit_op ? mode_bitw : cpu_req_in.wdata;

    // bit 0 held at zero so the reserved bit always reads back as zero
    // reserved bit masked
    assign mode_d = wr_mode ? (mode_new & `UCBS_MODE_WMASK) : mode_q;
    assign baud_d = wr_baud ? (cpu_req_in.wdata & `UCBS_BAUD_WMASK) : baud_q;

    // status has no write path at all
    // read by bit or byte
    wire [7:0] rd_byte = hit_mode   ? mode_q   :
                         hit_data   ? rx_buf_q :
                         hit_status ? status_q :
                         hit_baud   ? baud_q   : 8'h00;
    wire [7:0] rd_bit  = {7'h00, rd_byte[cpu_req_in.bit_sel]};
    wire [7:0] rdata_d = cpu_req_in.bit_op ? rd_bit : rd_byte;

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            mode_q   <= `UCBS_RESET_BYTE;
            baud_q   <= `UCBS_RESET_BYTE;
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            mode_q   <= mode_d;
            baud_q   <= baud_d;
            rvalid_q <= cpu_req_in.rd;
            if (cpu_req_in.rd) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign cpu_rdata_out  = rdata_q;
    assign cpu_rvalid_out = rvalid_q;

    ////////////////////////////////////////////////////////////////////////
    // baud rate generator

    wire [2:0] presc_sel = baud_q[`UCBS_BAUD_PS_HI:`UCBS_BAUD_PS_LO];
    wire [3:0] div_k     = baud_q[`UCBS_BAUD_DIV_HI:`UCBS_BAUD_DIV_LO];
    wire [4:0] div_term  = {1'b0, div_k} + `UCBS_DIV_TERM_OFS;

    logic [5:0] presc_q;
    logic       ext_prev_q;
    logic [4:0] bgc_q;
    logic       tx_phase_q;

    // m = code - 1, tick when the low m bits are all ones
    wire [2:0] presc_m    = presc_sel - 3'h1;
    wire [5:0] presc_mask = ~(`UCBS_PRESC_ONES << presc_m);
    wire       int_tick   = ((presc_q & presc_mask) == presc_mask);
    wire       ext_tick   = external_baud_clock_pin_in && !ext_prev_q;

    wire src_tick  = (presc_sel == `UCBS_SRC_EXT) ? ext_tick : int_tick;
    wire half_tick = src_tick && (bgc_q == div_term);
    // one bit spans two divider periods
    wire bit_tick  = half_tick && tx_phase_q;

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            presc_q    <= 6'h00;
            ext_prev_q <= 1'b0;
            bgc_q      <= 5'h00;
            tx_phase_q <= 1'b0;
        end else begin
            presc_q    <= presc_q + 6'h01;
            ext_prev_q <= external_baud_clock_pin_in;
            if (src_tick) begin
                bgc_q <= half_tick ? 5'h00 : bgc_q + 5'h01;
            end
            if (half_tick) begin
                tx_phase_q <= !tx_phase_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit fifo

    logic       fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic       fifo_pop;

    ucbs_fifo #(
        .WIDTH (`UCBS_FIFO_WIDTH),
        .DEPTH (`UCBS_FIFO_DEPTH)
    ) u_tx_fifo (
        .sys_clk_in    (sys_clk_in),
        .reset_in      (reset_in),
        .in_valid_in   (wr_data),
        .in_ready_out  (cpu_tx_ready_out),
        .in_data_in    (cpu_req_in.wdata),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // transmitter

    ucbs_pkg::ucbs_tx_state_t tx_state_q;
    logic [11:0]              tx_frame_q;
    logic [3:0]               tx_left_q;
    logic                     tx_done_q;

    wire par_on = (mode_w.par != ucbs_pkg::UCBS_PAR_NONE);

    // bit 7 dropped in seven-bit mode
    wire [7:0] tx_data = mode_w.cl ? fifo_out_data
                                   : {1'b0, fifo_out_data[6:0]};

    // parity bit from data ones count
    wire tx_par = (mode_w.par == ucbs_pkg::UCBS_PAR_EVEN) ? (^tx_data) :
                  (mode_w.par == ucbs_pkg::UCBS_PAR_ODD)  ? ~(^tx_data) :
                  1'b0;
    wire tx_pbit = par_on ? tx_par : 1'b1;

    wire [11:0] tx_frame_d = mode_w.cl
                           ? {2'b11, tx_pbit, tx_data, 1'b0}
                           : {3'b111, tx_pbit, tx_data[6:0], 1'b0};

    // stop count adds to frame length
    wire [3:0] tx_len = `UCBS_FRAME_BASE
                      + (mode_w.cl ? `UCBS_LEN8 : `UCBS_LEN7)
                      + {3'h0, par_on} + {3'h0, mode_w.sl};

    wire tx_start = (tx_state_q == ucbs_pkg::UCBS_TX_IDLE) && mode_w.txe
                  && fifo_out_valid && bit_tick;
    wire tx_last  = (tx_state_q == ucbs_pkg::UCBS_TX_SHIFT) && bit_tick
                  && (tx_left_q == 4'h1);

    assign fifo_pop = tx_start;

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            tx_state_q <= ucbs_pkg::UCBS_TX_IDLE;
            tx_frame_q <= 12'hfff;
            tx_left_q  <= 4'h0;
            tx_done_q  <= 1'b0;
        end else begin
            tx_done_q <= 1'b0;
            unique case (tx_state_q)
                ucbs_pkg::UCBS_TX_IDLE: begin
                    if (tx_start) begin
                        tx_frame_q <= tx_frame_d;
                        tx_left_q  <= tx_len;
                        tx_state_q <= ucbs_pkg::UCBS_TX_SHIFT;
                    end
                end
                ucbs_pkg::UCBS_TX_SHIFT: begin
                    if (bit_tick) begin
                        tx_frame_q <= {1'b1, tx_frame_q[11:1]};
                        tx_left_q  <= tx_left_q - 4'h1;
                    end
                    if (tx_last) begin
                        tx_done_q  <= 1'b1;
                        tx_state_q <= ucbs_pkg::UCBS_TX_IDLE;
                    end
                end
            endcase
        end
    end

    assign serial_out_pin_out          = tx_frame_q[0];
    assign serial_out_pin_oe_out       = mode_w.txe;
    assign transmit_done_interrupt_out = tx_done_q;

    ////////////////////////////////////////////////////////////////////////
    // receiver

    ucbs_pkg::ucbs_rx_state_t rx_state_q;
    logic [9:0]               rx_bits_q;
    logic [3:0]               rx_idx_q;
    logic [4:0]               rx_cnt_q;
    logic                     rx_phase_q;
    logic                     rx_prev_q;
    logic                     rx_irq_q;

    // own half-bit timer, restarted at the start edge for centring
    wire rx_half = src_tick && (rx_cnt_q == div_term);
    wire rx_samp = rx_half && rx_phase_q;

    wire rx_fall = rx_prev_q && !serial_in_pin_in;

    // data, parity and first stop only
    wire [3:0] rx_need = (mode_w.cl ? `UCBS_LEN8 : `UCBS_LEN7)
                       + {3'h0, par_on};

    // bit 7 zero in seven-bit mode
    wire [7:0] rx_data = mode_w.cl ? rx_bits_q[7:0]
                                   : {1'b0, rx_bits_q[6:0]};
    wire rx_pbit = mode_w.cl ? rx_bits_q[8] : rx_bits_q[7];
    wire rx_stop = par_on ? (mode_w.cl ? rx_bits_q[9] : rx_bits_q[8])
                          : (mode_w.cl ? rx_bits_q[8] : rx_bits_q[7]);
    wire rx_ones = (^rx_data) ^ rx_pbit;

    wire rx_pe = (mode_w.par == ucbs_pkg::UCBS_PAR_EVEN) ? rx_ones :
                 (mode_w.par == ucbs_pkg::UCBS_PAR_ODD)  ? ~rx_ones :
                 1'b0;
    wire rx_fe = !rx_stop;
    wire rx_err = rx_pe || rx_fe;
    wire rx_fin = (rx_state_q == ucbs_pkg::UCBS_RX_DONE);

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rx_state_q <= ucbs_pkg::UCBS_RX_IDLE;
            rx_bits_q  <= 10'h000;
            rx_idx_q   <= 4'h0;
            rx_cnt_q   <= 5'h00;
            rx_phase_q <= 1'b0;
            rx_prev_q  <= 1'b1;
        end else begin
            rx_prev_q <= serial_in_pin_in;
            if (src_tick) begin
                rx_cnt_q <= rx_half ? 5'h00 : rx_cnt_q + 5'h01;
            end
            if (rx_half) begin
                rx_phase_q <= !rx_phase_q;
            end
            unique case (rx_state_q)
                ucbs_pkg::UCBS_RX_IDLE: begin
                    if (mode_w.rxe && rx_fall) begin
                        rx_cnt_q   <= 5'h00;
                        rx_phase_q <= 1'b0;
                        rx_state_q <= ucbs_pkg::UCBS_RX_START;
                    end
                end
                ucbs_pkg::UCBS_RX_START: begin
                    // half bit later: centre of start
                    if (rx_half) begin
                        // next sample a full bit on, not half
                        rx_phase_q <= 1'b0;
                        rx_idx_q   <= 4'h0;
                        rx_state_q <= serial_in_pin_in
                                    ? ucbs_pkg::UCBS_RX_IDLE
                                    : ucbs_pkg::UCBS_RX_BITS;
                    end
                end
                ucbs_pkg::UCBS_RX_BITS: begin
                    if (rx_samp) begin
                        rx_bits_q[rx_idx_q] <= serial_in_pin_in;
                        rx_idx_q <= rx_idx_q + 4'h1;
                        if (rx_idx_q == rx_need) begin
                            rx_state_q <= ucbs_pkg::UCBS_RX_DONE;
                        end
                    end
                end
                ucbs_pkg::UCBS_RX_DONE: begin
                    rx_state_q <= ucbs_pkg::UCBS_RX_IDLE;
                end
            endcase
            if (!mode_w.rxe) begin
                rx_state_q <= ucbs_pkg::UCBS_RX_IDLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive buffer and error status

    // a read in the same cycle already took the old byte
    wire rx_ove = unread_q && !rd_data;

    always_comb begin
        status_d = status_q;
        if (rx_fin) begin
            status_d[`UCBS_STAT_PE]  = rx_pe;
            status_d[`UCBS_STAT_FE]  = rx_fe;
            status_d[`UCBS_STAT_OVE] = rx_ove;
        end
        status_d[7:3] = 5'h00;
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            status_q <= `UCBS_RESET_BYTE;
            rx_buf_q <= 8'h00;
            unread_q <= 1'b0;
            rx_irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            if (rx_fin) begin
                rx_buf_q <= rx_data;
            end
            // completion beats a simultaneous read
            unread_q <= rx_fin || (unread_q && !rd_data);
            rx_irq_q <= rx_fin && !(rx_err && mode_w.isrm);
        end
    end

    assign receive_done_interrupt_out = rx_irq_q;

endmodule

`default_nettype wire

// File: verif/ucbs_uart_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ucbs_uart_monitor (
    input wire logic                    sys_clk_in,
    input wire logic                    reset_in,
    input wire ucbs_pkg::ucbs_cpu_req_t cpu_req_in,
    input wire logic [7:0]              cpu_rdata_out,
    input wire logic                    cpu_rvalid_out,
    input wire logic                    cpu_tx_ready_out,
    input wire logic                    serial_out_pin_out,
    input wire logic                    serial_out_pin_oe_out,
    input wire logic                    transmit_done_interrupt_out,
    input wire logic                    receive_done_interrupt_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    a_read_answer: assert property (
        cpu_req_in.rd |=> cpu_rvalid_out) else $error("no answer");
    a_no_stray: assert property (
        cpu_rvalid_out |-> $past(cpu_req_in.rd)) else $error("stray data");
    a_status_top_zero: assert property (
        cpu_req_in.rd && cpu_req_in.addr == 16'hff72
        |=> cpu_rdata_out[7:3] == 5'h00) else $error("status top set");
    a_bit_read_narrow: assert property (
        cpu_req_in.rd && cpu_req_in.bit_op |=> cpu_rdata_out[7:1] == 7'h00)
        else $error("bit read wide");
    a_reset_idle: assert property (
        $fell(reset_in) |-> serial_out_pin_out && !serial_out_pin_oe_out
        && cpu_tx_ready_out && !cpu_rvalid_out) else $error("bad reset");
    a_tx_done_pulse: assert property (
        transmit_done_interrupt_out |=> !transmit_done_interrupt_out)
        else $error("tx done long");
    a_rx_done_pulse: assert property (
        receive_done_interrupt_out |=> !receive_done_interrupt_out)
        else $error("rx done long");
    // shortest legal bit is 32 clocks, so 9 steady cycles always hold
    a_bit_min_width: assert property (
        $changed(serial_out_pin_out) |=> $stable(serial_out_pin_out)[*8])
        else $error("bit too short");
    a_done_after_stop: assert property (
        transmit_done_interrupt_out |-> $past(serial_out_pin_out, 3))
        else $error("done without stop");
    c_rx_done: cover property (receive_done_interrupt_out);
    c_tx_done: cover property (transmit_done_interrupt_out);
    c_fifo_full: cover property (!cpu_tx_ready_out);
endmodule
bind ucbs_uart ucbs_uart_monitor mon_u (.sys_clk_in, .reset_in, .cpu_req_in,
    .cpu_rdata_out, .cpu_rvalid_out, .cpu_tx_ready_out, .serial_out_pin_out,
    .serial_out_pin_oe_out, .transmit_done_interrupt_out,
    .receive_done_interrupt_out);
`default_nettype wire

// File: verif/ucbs_remote_model.sv
`timescale 1ns/1ps
`default_nettype none
module ucbs_remote_model (
    input  wire logic   sys_clk_in,
    input  wire logic   line_in,
    input  wire logic   line_oe_in,
    output logic        line_out,
    output logic        got_out,
    output logic [11:0] bits_out
);
    int bit_len = 32;
    int nbits = 10;
    initial begin
        line_out = 1'b1;
        got_out = 1'b0;
        bits_out = 12'h000;
    end
    // start bit then frame lsb first
    task automatic send(input logic [11:0] f, input int n);
        line_out = 1'b0;
        repeat (bit_len) @(negedge sys_clk_in);
        for (int b = 0; b < n; b++) begin
            line_out = f[b];
            repeat (bit_len) @(negedge sys_clk_in);
        end
        line_out = 1'b1;
    endtask
    always begin
        @(negedge line_in iff line_oe_in);
        bits_out = 12'h000;
        repeat (bit_len / 2) @(negedge sys_clk_in);
        for (int b = 0; b < nbits; b++) begin
            repeat (bit_len) @(negedge sys_clk_in);
            bits_out[b] = line_in;
        end
        got_out = 1'b1;
        @(negedge sys_clk_in);
        got_out = 1'b0;
    end
endmodule
`default_nettype wire

// File: verif/uart_config_baud_status_test.sv
`timescale 1ns/1ps
`default_nettype none
module uart_config_baud_status_test;
    logic                    sys_clk_in = 1'b0;
    logic                    reset_in = 1'b1;
    logic                    ext_clk = 1'b0;
    ucbs_pkg::ucbs_cpu_req_t req = '0;
    logic [7:0]              rdata, d;
    logic [11:0]             bits;
    logic                    rvalid, tx_ready, sout, soe, sin, got;
    logic                    tx_done, rx_done;
    logic [7:0]              exp_rd[$];
    logic [11:0]             exp_tx[$];
    logic [7:0]              codes[2] = '{8'h21, 8'h0e};
    int fail_count = 0;
    int compares = 0;
    int seed = 32'h1df5;
    int rx_count = 0;
    int refused = 0;
    int c;
    always #12.5 sys_clk_in = ~sys_clk_in;
    always @(negedge sys_clk_in) ext_clk <= ~ext_clk;
    ucbs_uart dut_u (.sys_clk_in, .reset_in, .cpu_req_in(req),
        .cpu_rdata_out(rdata), .cpu_rvalid_out(rvalid),
        .cpu_tx_ready_out(tx_ready), .serial_in_pin_in(sin),
        .serial_out_pin_out(sout), .serial_out_pin_oe_out(soe),
        .external_baud_clock_pin_in(ext_clk),
        .transmit_done_interrupt_out(tx_done),
        .receive_done_interrupt_out(rx_done));
    ucbs_remote_model remote_u (.sys_clk_in, .line_in(sout),
        .line_oe_in(soe), .line_out(sin), .got_out(got), .bits_out(bits));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [11:0] g, input logic [11:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // a read carries its expected byte in v
    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [7:0] v, input logic b = 1'b0,
                       input logic [2:0] s = 3'h0);
        if (!w)
            exp_rd.push_back(v);
        req = '{w, !w, b, s, a, w ? v : 8'h00};
        @(negedge sys_clk_in);
        req = '0;
        @(negedge sys_clk_in);
    endtask
    function automatic int fbits(input logic [7:0] m);
        return (m[3] ? 8 : 7) + int'(m[5:4] != 2'b00) + int'(m[2]) + 1;
    endfunction
    function automatic logic [11:0] frame(input logic [7:0] dv,
                                          input logic [7:0] m);
        logic [11:0] f;
        logic [7:0]  x;
        x = m[3] ? dv : {1'b0, dv[6:0]};
        f = m[3] ? {4'hf, x} : {5'h1f, x[6:0]};
        if (m[5:4] != 2'b00)
            f[m[3] ? 8 : 7] = (m[5:4] == 2'b01) ? 1'b0 : ^x ^ ~m[4];
        return f & ~(12'hfff << fbits(m));
    endfunction
    task automatic sendw(input logic [11:0] f, input int n);
        remote_u.send(f, n);
        repeat (8) @(negedge sys_clk_in);
    endtask
    // both directions at once, then buffer and status
    task automatic run(input logic [7:0] dv, input logic [7:0] m);
        remote_u.nbits = fbits(m);
        exp_tx.push_back(frame(dv, m));
        bus(1'b1, 16'hff71, dv);
        remote_u.send(frame(dv, m), fbits(m));
        repeat (2 * remote_u.bit_len) @(negedge sys_clk_in);
        bus(1'b0, 16'hff71, m[3] ? dv : {1'b0, dv[6:0]});
        bus(1'b0, 16'hff72, 8'h00);
    endtask
    always @(posedge sys_clk_in) begin
        if (rvalid === 1'b1)
            check(rdata, exp_rd.size() > 0 ? exp_rd.pop_front() : 8'hxx);
        if (got === 1'b1)
            check(bits, exp_tx.size() > 0 ? exp_tx.pop_front() : 12'hxxx);
        if (rx_done === 1'b1)
            rx_count++;
    end
    initial begin
        repeat (60000) @(posedge sys_clk_in);
        fail_count++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(negedge sys_clk_in);
        reset_in = 1'b0;
        bus(1'b0, 16'hff70, 8'h00);
        bus(1'b0, 16'hff76, 8'h00);
        bus(1'b0, 16'hff7f, 8'h00);
        bus(1'b1, 16'hff76, 8'hff);
        bus(1'b0, 16'hff76, 8'h7f);
        bus(1'b1, 16'hff70, 8'hfe);
        bus(1'b1, 16'hff72, 8'h07);
        bus(1'b0, 16'hff72, 8'h00);
        bus(1'b0, 16'hff70, 8'h01, 1'b1, 3'h7);
        bus(1'b1, 16'hff70, 8'h00, 1'b1, 3'h7);
        bus(1'b0, 16'hff70, 8'h7e);
        bus(1'b1, 16'hff76, 8'h10);
        // every parity, length and stop combination
        for (int i = 0; i < 16; i++) begin
            bus(1'b1, 16'hff70, {2'b11, i[3:0], 2'b00});
            d = 8'($random(seed));
            run(d, {2'b11, i[3:0], 2'b00});
        end
        check(12'(rx_count), 12'd16);
        // overfill the transmit queue, then drain it
        bus(1'b1, 16'hff70, 8'h88);
        remote_u.nbits = 9;
        for (int j = 0; j < 20; j++) begin
            d = 8'($random(seed));
            if (tx_ready === 1'b1)
                exp_tx.push_back(frame(d, 8'h88));
            else
                refused++;
            bus(1'b1, 16'hff71, d);
        end
        check(12'(refused > 0), 12'h001);
        for (int k = 0; k < 9000 && exp_tx.size() > 0; k++)
            @(negedge sys_clk_in);
        check(12'(exp_tx.size()), 12'h000);
        bus(1'b1, 16'hff70, 8'hc8);
        foreach (codes[i]) begin
            // baud written with the link idle
            bus(1'b1, 16'hff76, codes[i]);
            c = 2 * (int'(codes[i][3:0]) + 16);
            remote_u.bit_len = (codes[i][6:4] == 3'h0) ? 2 * c
                : c * (1 << (int'(codes[i][6:4]) - 1));
            run(8'($random(seed)), 8'hc8);
        end
        bus(1'b1, 16'hff76, 8'h10);
        remote_u.bit_len = 32;
        bus(1'b1, 16'hff70, 8'h4a);
        check(12'(soe), 12'h000);
        c = rx_count;
        sendw(frame(8'h5a, 8'h4a) ^ 12'h100, 10);
        bus(1'b0, 16'hff72, 8'h02);
        sendw(frame(8'h33, 8'h4a) ^ 12'h200, 10);
        bus(1'b0, 16'hff72, 8'h01);
        sendw(frame(8'hc5, 8'h4a), 10);
        bus(1'b0, 16'hff72, 8'h01);
        bus(1'b0, 16'hff72, 8'h01, 1'b1, 3'h0);
        bus(1'b0, 16'hff71, 8'hc5);
        check(12'(rx_count - c), 12'h002);
        repeat (4) @(negedge sys_clk_in);
        report_and_stop();
    end
endmodule
`default_nettype wire
